/* rtl/spr_top.sv */
// Shared divider, watchdog counter and reset-cause flags with Wishbone
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module spr_top (
	input  wire logic              clock,
	input  wire logic              reset_n,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire spr_pkg::spr_core_t core,
	output logic                   timer_tick,
	output logic                   watchdog_reset,
	output logic                   osc_halted,
	output logic                   irq
);

	// ==========================================================
	// State
	spr_pkg::spr_pwr_t pwr_reg;
	logic [7:0]  div_reg;
	logic [7:0]  wdt_reg;
	logic [7:0]  option_reg;
	logic [7:0]  irq_mask_reg;
	logic [spr_pkg::SPR_NEV-1:0] irq_stat_reg;
	logic        to_reg;
	logic        pd_reg;
	logic        pw_reg;
	logic        cw_reg;
	logic        master_clear_pin_q_reg;
	logic        ack_reg;
	logic [31:0] dat_reg;
	logic        tick_reg;
	logic        wdrst_reg;
	logic        irq_reg;

	// ==========================================================
	// Decoded controls
	logic        assign_wd;
	logic [2:0]  ratio;
	logic [7:0]  mask_t;
	logic [7:0]  mask_w;
	logic        awake;
	logic        asleep;
	logic        hit_t;
	logic        hit_w;
	logic        wd_tick;
	logic        tick_next;
	logic        clr_ok;
	logic        slp_ok;
	logic        tw_ok;
	logic        master_clear_pin;
	logic        wdt_to;
	logic        rst_int;
	logic        wake;
	logic [spr_pkg::SPR_NEV-1:0] ev;

	// Option decode: assign bit and ratio field
	assign assign_wd = option_reg[spr_pkg::SPR_OPT_ASSIGN];
	assign ratio     = option_reg[2:0];

	// Power-of-two masks, timer 2..256 and watchdog 1..128
	assign mask_t = 8'((9'h002 << ratio) - 9'h001);
	assign mask_w = 8'((9'h001 << ratio) - 9'h001);
	assign hit_t  = &(div_reg | ~mask_t);
	assign hit_w  = &(div_reg | ~mask_w);

	// Instruction events only exist while the clock runs
	assign awake  = (pwr_reg == spr_pkg::SPR_RUN);
	assign asleep = (pwr_reg == spr_pkg::SPR_SLEEP);
	assign clr_ok = awake & core.watchdog_clear_instr;
	assign slp_ok = awake & core.sleep_instr;
	assign tw_ok  = awake & core.timer_write;
	assign master_clear_pin   = ~core.master_clear_pin_n;

	// Divider owner is divided, other user undivided
	assign tick_next = awake & (assign_wd | hit_t);
	assign wd_tick   = assign_wd ? hit_w : 1'b1;

	// Watchdog overflow, suppressed by a clear in the same cycle
	assign wdt_to  = wd_tick & (wdt_reg == spr_pkg::SPR_FULL8) &
		~clr_ok & ~slp_ok;
	assign rst_int = wdt_to | master_clear_pin;
	assign wake    = asleep & (wdt_to | master_clear_pin | core.pin_change |
		core.cmp_change);

	// ==========================================================
	// Shared 8-bit divider, no bus path to its count
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div_reg <= spr_pkg::SPR_ZERO8;
		end else if (rst_int) begin
			div_reg <= spr_pkg::SPR_ZERO8;
		end else if (!assign_wd && tw_ok) begin
			div_reg <= spr_pkg::SPR_ZERO8;
		end else if (assign_wd && (clr_ok || slp_ok)) begin
			div_reg <= spr_pkg::SPR_ZERO8;
		end else if (assign_wd || awake) begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// Watchdog counter, runs on its own source also in sleep
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wdt_reg <= spr_pkg::SPR_ZERO8;
		end else if (rst_int || clr_ok || slp_ok) begin
			wdt_reg <= spr_pkg::SPR_ZERO8;
		end else if (wd_tick) begin
			wdt_reg <= wdt_reg + 8'h01;
		end
	end

	// Power state: sleep halts the instruction clock
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pwr_reg <= spr_pkg::SPR_RUN;
		end else begin
			case (pwr_reg)
				spr_pkg::SPR_RUN: begin
					if (slp_ok && !rst_int) begin
						pwr_reg <= spr_pkg::SPR_SLEEP;
					end
				end
				spr_pkg::SPR_SLEEP: begin
					if (wake) begin
						pwr_reg <= spr_pkg::SPR_RUN;
					end
				end
				default: pwr_reg <= spr_pkg::SPR_RUN;
			endcase
		end
	end

	// ==========================================================
	// Reset-cause flags, power-up gives time-out 1 power-down 1
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
			pw_reg <= 1'b0;
			cw_reg <= 1'b0;
		end else if (wdt_to) begin
			to_reg <= 1'b0;
			if (asleep) begin
				pd_reg <= 1'b0;
			end
			pw_reg <= 1'b0;
			cw_reg <= 1'b0;
		end else if (master_clear_pin) begin
			if (asleep) begin
				to_reg <= 1'b1;
				pd_reg <= 1'b0;
			end
			pw_reg <= 1'b0;
			cw_reg <= 1'b0;
		end else if (asleep && core.pin_change) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b0;
			pw_reg <= 1'b1;
			cw_reg <= 1'b0;
		end else if (asleep && core.cmp_change) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b0;
			pw_reg <= 1'b0;
			cw_reg <= 1'b1;
		end else if (clr_ok) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
		end else if (slp_ok) begin
			to_reg <= 1'b1;
			pd_reg <= 1'b0;
		end
	end

	// Master clear edge for the event bit
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			master_clear_pin_q_reg <= 1'b0;
		end else begin
			master_clear_pin_q_reg <= master_clear_pin;
		end
	end

	// ==========================================================
	// Wishbone slave, ack one cycle after the request
	logic       req;
	logic       hit_wr;
	logic       rd_stat;
	logic [5:0] idx;
	logic [7:0] rd_byte;

	assign req     = wb_cyc_i & wb_stb_i;
	assign idx     = wb_adr_i[7:2];
	assign hit_wr  = req & ack_reg & wb_we_i & wb_sel_i[0] &
		(wb_adr_i[1:0] == 2'b00);
	assign rd_stat = req & ack_reg & ~wb_we_i &
		(wb_adr_i[1:0] == 2'b00) & (idx == spr_pkg::SPR_IDX_IRQ_STAT);

	// Read mux, unmapped reads zero, divider not visible
	always_comb begin
		rd_byte = spr_pkg::SPR_ZERO8;
		if (wb_adr_i[1:0] == 2'b00) begin
			case (idx)
				spr_pkg::SPR_IDX_STATUS: begin
					rd_byte[spr_pkg::SPR_ST_PINWAKE] = pw_reg;
					rd_byte[spr_pkg::SPR_ST_CMPWAKE] = cw_reg;
					rd_byte[spr_pkg::SPR_ST_TIMEOUT] = to_reg;
					rd_byte[spr_pkg::SPR_ST_PWRDOWN] = pd_reg;
				end
				spr_pkg::SPR_IDX_OPTION:   rd_byte = option_reg;
				spr_pkg::SPR_IDX_IRQ_STAT:
					rd_byte = {5'h00, irq_stat_reg};
				spr_pkg::SPR_IDX_IRQ_MASK: rd_byte = irq_mask_reg;
				default:                   rd_byte = spr_pkg::SPR_ZERO8;
			endcase
		end
	end

	// Ack and read data
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req && !ack_reg) begin
				dat_reg <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Option and mask writes take effect at the ack edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			option_reg   <= spr_pkg::SPR_OPTION_RST;
			irq_mask_reg <= spr_pkg::SPR_ZERO8;
		end else if (hit_wr) begin
			if (idx == spr_pkg::SPR_IDX_OPTION) begin
				option_reg <= wb_dat_i[7:0];
			end
			if (idx == spr_pkg::SPR_IDX_IRQ_MASK) begin
				irq_mask_reg <= wb_dat_i[7:0];
			end
		end
	end

	// ==========================================================
	// Sticky events, read clears, a new event wins
	assign ev[spr_pkg::SPR_EV_WDT]  = wdt_to;
	assign ev[spr_pkg::SPR_EV_WAKE] = wake;
	assign ev[spr_pkg::SPR_EV_MASTER_CLEAR_PIN] = master_clear_pin & ~master_clear_pin_q_reg;

	for (genvar i = 0; i < spr_pkg::SPR_NEV; i++) begin : g_irq
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				irq_stat_reg[i] <= 1'b0;
			end else if (ev[i]) begin
				irq_stat_reg[i] <= 1'b1;
			end else if (rd_stat) begin
				irq_stat_reg[i] <= 1'b0;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_reg  <= 1'b0;
			wdrst_reg <= 1'b0;
			irq_reg   <= 1'b0;
		end else begin
			tick_reg  <= tick_next;
			wdrst_reg <= wdt_to;
			irq_reg   <= |(irq_stat_reg & irq_mask_reg[2:0]);
		end
	end

	assign wb_ack_o       = ack_reg;
	assign wb_dat_o       = dat_reg;
	assign timer_tick     = tick_reg;
	assign watchdog_reset = wdrst_reg;
	assign osc_halted     = pwr_reg[1];
	assign irq            = irq_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	sequence s_sleep_start;
		slp_ok && !rst_int;
	endsequence
	sequence s_asleep_two;
		(pwr_reg == spr_pkg::SPR_SLEEP) [*2];
	endsequence
	AST_TMR_WRITE: assert property (
		tw_ok && !assign_wd && !rst_int |=> div_reg == 8'h00)
		else $error("timer write left divider nonzero");
	AST_WDT_CLEAR: assert property (
		clr_ok && assign_wd && !master_clear_pin |=>
		div_reg == 8'h00 && wdt_reg == 8'h00 && to_reg && pd_reg)
		else $error("watchdog clear did not reset state");
	AST_MASTER_CLEAR_PIN_DIV: assert property (
		master_clear_pin |=> div_reg == 8'h00)
		else $error("divider not zero after reset");
	AST_WDT_SLEEP: assert property (
		wdt_to && asleep |=>
		!to_reg && !pd_reg && !pw_reg && !cw_reg && awake)
		else $error("watchdog wake flags wrong");
	AST_WDT_RUN: assert property (
		wdt_to && awake |=> !to_reg && pd_reg == $past(pd_reg)
		&& watchdog_reset)
		else $error("watchdog time-out flags wrong");
	AST_MASTER_CLEAR_PIN_SLEEP: assert property (
		master_clear_pin && asleep && !wdt_to |=> to_reg && !pd_reg && !pw_reg)
		else $error("master clear wake flags wrong");
	AST_MASTER_CLEAR_PIN_RUN: assert property (
		master_clear_pin && awake && !wdt_to |=> $stable(to_reg) && $stable(pd_reg))
		else $error("master clear changed flags");
	AST_PIN_WAKE: assert property (
		asleep && core.pin_change && !rst_int |=>
		pw_reg && !cw_reg && to_reg && !pd_reg)
		else $error("pin wake flags wrong");
	AST_SLEEP: assert property (
		s_sleep_start |=> asleep && wdt_reg == 8'h00 && to_reg
		&& !pd_reg && pw_reg == $past(pw_reg))
		else $error("sleep entry state wrong");
	AST_OSC_HALT: assert property (
		s_sleep_start ##1 s_asleep_two |-> !timer_tick)
		else $error("timer ticked while asleep");
	AST_UNDIV: assert property (
		reset_n && assign_wd && awake |=> timer_tick) // Not at release
		else $error("timer divided while divider given away");

endmodule : spr_top

/* rtl/spr_pkg.sv */
// Constants and types for the shared divider and reset-status block
// Contract
// - One 8-bit counter serves as timer prescaler or watchdog postscaler.
// - Divider belongs to one user; the other user runs undivided.
// - Assign bit and 3-bit ratio come from low four option bits.
// - Any timer count write clears the divider while timer owns it.
// - Watchdog clear zeroes watchdog and divider while watchdog owns it.
// - Software can neither read nor write the divider count.
// - Every reset zeroes all divider bits.
// - Watchdog wake gives both flags 0; awake time-out clears time-out, keeps power-down.
// - Master-clear wake 1/0, power-up 1/1, awake master clear unchanged.
// - Pin wake sets pin flag, comparator wake its flag; 1/0 flags.
// - Flags change only on a reset, wake, watchdog clear or sleep; awake master clear clears only pin and comparator flags.
// - Watchdog clear zeroes counter, owned divider, sets both flags.
// - Sleep zeroes watchdog and owned divider, sets time-out, clears power-down.
// - After sleep the instruction clock halts until wake or reset.
// - Assign bit 0 gives divider to timer, 1 to watchdog.
// - Top status bit set only for pin-change wake resets.
package spr_pkg;

	// ==========================================================
	// Register indexes, byte address is four times the index
	localparam logic [5:0] SPR_IDX_STATUS   = 6'h03;
	localparam logic [5:0] SPR_IDX_OPTION   = 6'h04;
	localparam logic [5:0] SPR_IDX_IRQ_STAT = 6'h05;
	localparam logic [5:0] SPR_IDX_IRQ_MASK = 6'h06;

	// ==========================================================
	// Field positions and reset values
	localparam int unsigned SPR_OPT_ASSIGN = 3;
	localparam int unsigned SPR_ST_PINWAKE = 7;
	localparam int unsigned SPR_ST_CMPWAKE = 6;
	localparam int unsigned SPR_ST_TIMEOUT = 4;
	localparam int unsigned SPR_ST_PWRDOWN = 3;
	localparam logic [7:0]  SPR_OPTION_RST = 8'hff;
	localparam logic [7:0]  SPR_ZERO8      = 8'h00;
	localparam logic [7:0]  SPR_FULL8      = 8'hff;

	// ==========================================================
	// Interrupt event bits
	localparam int unsigned SPR_NEV     = 3;
	localparam int unsigned SPR_EV_WDT  = 0;
	localparam int unsigned SPR_EV_WAKE = 1;
	localparam int unsigned SPR_EV_MASTER_CLEAR_PIN = 2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SPR_RUN   = 2'b01,
		SPR_SLEEP = 2'b10
	} spr_pwr_t;

	typedef struct packed {
		logic timer_write;
		logic watchdog_clear_instr;
		logic sleep_instr;
		logic pin_change;
		logic cmp_change;
		logic master_clear_pin_n;
	} spr_core_t;

endpackage : spr_pkg

/* dv/spr_core_model.sv */
// Processor core model that issues instruction and wake events
`timescale 1ns/1ps
module spr_core_model (
	input  wire logic       clock,
	output spr_pkg::spr_core_t core
);
	// ==========================================================
	// Idle core: no instruction, master clear released
	initial begin
		core = 6'h01;
	end

	// Drive one core bit to a level right after an edge
	task set_bit(input int b, input logic v);
		core[b] <= v;
	endtask : set_bit

	// One-cycle instruction or wake pulse
	task pulse(input int b);
		core[b] <= 1'b1;
		@(posedge clock);
		core[b] <= 1'b0;
	endtask : pulse

	// Master clear held low for n cycles
	task master_clear_pin(input int n);
		core.master_clear_pin_n <= 1'b0;
		repeat (n) @(posedge clock);
		core.master_clear_pin_n <= 1'b1;
	endtask : master_clear_pin

	// Safe hand-over of the divider from timer to watchdog
	task tmr_to_wdt();
		pulse(4);
		pulse(5);
	endtask : tmr_to_wdt
endmodule : spr_core_model

/* dv/tb_spr_top.sv */
// Self-checking bench for the shared divider and reset-status block
`timescale 1ns/1ps
module tb_spr_top;
	logic               clock, reset_n, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0]         wb_adr, rd;
	logic [3:0]         wb_sel, sel_v;
	logic [31:0]        wb_dat_i, wb_dat_o;
	logic               timer_tick, watchdog_reset, osc_halted, irq;
	spr_pkg::spr_core_t core;
	int                 n_mismatch = 0;
	int                 n_tests = 0;
	int                 cyc_cnt = 0;
	int                 c;
	localparam logic [7:0] A_ST = 8'h0c;
	localparam logic [7:0] A_OPT = 8'h10;
	localparam logic [7:0] A_IST = 8'h14;
	localparam logic [7:0] A_IMK = 8'h18;

	// ==========================================================
	// Design, core model and clock
	spr_top spr_top_inst (.clock(clock), .reset_n(reset_n),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .core(core),
		.timer_tick(timer_tick), .watchdog_reset(watchdog_reset),
		.osc_halted(osc_halted), .irq(irq));
	spr_core_model spr_core_model_inst (.clock(clock), .core(core));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ==========================================================
	// Verdict, compare and bus tasks
	task stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk

	// Classic single cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= sel_v;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'b1 && n < 40);
		if (n >= 40) n_mismatch++;
		rd = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clock);
	endtask : wb

	task rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, e, rd);
	endtask : rdchk

	// Cycles from a watchdog clear to the overflow pulse
	task wdt_time(input logic [2:0] r, input int e);
		wb(1'b1, A_OPT, {5'h01, r});
		spr_core_model_inst.pulse(4);
		c = 0;
		while (watchdog_reset !== 1'b1 && c < 2000) begin
			@(posedge clock);
			c++;
		end
		n_tests++;
		if (c < e - 4 || c > e + 4) begin
			$display("ERROR wdt_period expected %0d seen %0d", e, c);
			n_mismatch++;
		end
	endtask : wdt_time

	// Timer ticks over 64 cycles, with a timer write every 4 cycles when tw is nonzero
	task ticks(input logic [7:0] opt, input int tw, input int e);
		int i;
		wb(1'b1, A_OPT, opt);
		spr_core_model_inst.pulse(4);
		c = 0;
		for (i = 0; i < 64; i++) begin
			spr_core_model_inst.set_bit(5, tw > 0 && i % 4 == 0);
			@(posedge clock);
			if (timer_tick === 1'b1) c++;
		end
		spr_core_model_inst.set_bit(5, 1'b0);
		chk("timer_ticks", e[7:0], c[7:0]);
	endtask : ticks

	// Sleep, then wake by pin, comparator or master clear
	task sleep_wake(input int b, input logic [7:0] e);
		spr_core_model_inst.pulse(4);
		spr_core_model_inst.pulse(3);
		@(posedge clock);
		chk("halted", 8'h01, {7'h0, osc_halted});
		if (b == 0) spr_core_model_inst.master_clear_pin(3);
		else spr_core_model_inst.pulse(b);
		repeat (3) @(posedge clock);
		chk("awake", 8'h00, {7'h0, osc_halted});
		rdchk(A_ST, e, "status_wake");
	endtask : sleep_wake

	// ==========================================================
	// Hang guard
	always @(posedge clock) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ==========================================================
	// Test sequence
	initial begin
		{reset_n, wb_cyc, wb_stb, wb_we} = 4'h0;
		{wb_adr, wb_sel, wb_dat_i} = 44'h0;
		sel_v = 4'h1;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rdchk(A_ST, 8'h18, "status_por");
		rdchk(A_OPT, 8'hff, "option_rst");
		sel_v = 4'h0;
		wb(1'b1, A_OPT, 8'h00);
		sel_v = 4'h1;
		wb(1'b1, 8'h12, 8'h00);
		rdchk(A_OPT, 8'hff, "option_ignored");
		rdchk(8'h40, 8'h00, "unmapped");
		wb(1'b1, A_IMK, 8'h00);
		wb(1'b0, A_IST, 8'h00);
		$display("test reset done");
		wdt_time(3'd0, 256);
		chk("irq_masked", 8'h00, {7'h0, irq});
		spr_core_model_inst.pulse(2);
		rdchk(A_ST, 8'h08, "status_wdt");
		wb(1'b1, A_IMK, 8'h01);
		repeat (2) @(posedge clock);
		chk("irq_on", 8'h01, {7'h0, irq});
		rdchk(A_IST, 8'h01, "irq_stat");
		repeat (2) @(posedge clock);
		chk("irq_off", 8'h00, {7'h0, irq});
		wdt_time(3'd1, 512);
		$display("test watchdog done");
		ticks(8'h00, 0, 32);
		ticks(8'h02, 0, 8);
		ticks(8'h02, 4, 0);
		spr_core_model_inst.tmr_to_wdt();
		wb(1'b1, A_OPT, 8'h0f);
		spr_core_model_inst.pulse(4);
		wb(1'b1, A_OPT, 8'h08);
		$display("test timer done");
		sleep_wake(2, 8'h90);
		rdchk(A_IST, 8'h03, "irq_stat_wake");
		spr_core_model_inst.master_clear_pin(3);
		rdchk(A_ST, 8'h10, "status_master_clear_pin");
		rdchk(A_IST, 8'h04, "irq_stat_master_clear_pin");
		sleep_wake(1, 8'h50);
		sleep_wake(0, 8'h10);
		spr_core_model_inst.pulse(4);
		spr_core_model_inst.pulse(3);
		c = 0;
		while (osc_halted !== 1'b0 && c < 400 || c < 2) begin
			@(posedge clock);
			c++;
		end
		chk("sleep_wdt", 8'h01, {7'h0, c > 250 && c < 262});
		rdchk(A_ST, 8'h00, "status_wdt_wake");
		$display("test sleep done");
		stop_test();
	end
endmodule : tb_spr_top
